//--- verilog/bsd_pkg.sv
// shared constants, codes and types of the switch diagnostic sequencer
package bsd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // channel geometry
    localparam int CH_N = 14;
    localparam int DW = 14;

    ////////////////////////////////////////////////////////////////////////
    // scan_config_select codes of the four diagnostic modes
    localparam logic [2:0] CFG_SHORT = 3'h4;
    localparam logic [2:0] CFG_OPEN = 3'h5;
    localparam logic [2:0] CFG_ODD = 3'h6;
    localparam logic [2:0] CFG_EVEN = 3'h7;

    // nonadjacent switch patterns for the sense-wire modes
    localparam logic [13:0] PAT_ODD = 14'h1555;
    localparam logic [13:0] PAT_EVEN = 14'h2aaa;

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets, one aligned word each
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_MEAS_A = 6'h04;
    localparam logic [5:0] OFS_MEAS_B = 6'h08;
    localparam logic [5:0] OFS_BAL_EN = 6'h0c;
    localparam logic [5:0] OFS_POLARITY = 6'h10;
    localparam logic [5:0] OFS_DIAG_SEL = 6'h14;
    localparam logic [5:0] OFS_TOP_CELL = 6'h18;
    localparam logic [5:0] OFS_SHORT_THR = 6'h1c;
    localparam logic [5:0] OFS_LOW_THR = 6'h20;
    localparam logic [5:0] OFS_HIGH_THR = 6'h24;
    localparam logic [5:0] OFS_ALERT = 6'h28;
    localparam logic [5:0] OFS_STATUS = 6'h2c;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_ALT_BIT = 3;
    localparam int CTRL_OVS_LSB = 4;
    localparam int CTRL_START_BIT = 8;
    localparam int CTRL_BUSY_BIT = 9;
    localparam int ALERT_SUM_BIT = 16;
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;

    ////////////////////////////////////////////////////////////////////////
    // reset values that are not zero
    localparam logic [15:0] RST_MEAS_A = 16'h3fff;
    localparam logic [3:0] RST_TOP_CELL = 4'he;
    localparam logic [13:0] RST_HIGH_THR = 14'h3fff;

    // scan sequencing phases
    typedef enum logic [1:0] {BSD_IDLE, BSD_ARM, BSD_RUN} bsd_phase_t;

    // any of the four switch diagnostic modes
    function automatic logic isDiag(input logic [2:0] sel);
        return sel[2];
    endfunction : isDiag

    // modes that convert bipolar with one sample per channel
    function automatic logic isBipolarMode(input logic [2:0] sel);
        return sel[2] & (sel[1] | sel[0]);
    endfunction : isBipolarMode

endpackage : bsd_pkg

//--- verilog/bsd_override.sv
// effective acquisition configuration with diagnostic overrides applied
`timescale 1ns/10ps
module bsd_override (
    input wire logic running,
    input wire logic [2:0] sel,
    input wire logic [15:0] measA,
    input wire logic [5:0] measB,
    input wire logic [13:0] balEn,
    input wire logic [13:0] polarity,
    input wire logic [3:0] diagSel,
    input wire logic altSel,
    input wire logic [3:0] ovs,
    input wire logic [3:0] topCell,
    output logic [15:0] effMeasA,
    output logic [5:0] effMeasB,
    output logic [13:0] effBal,
    output logic [3:0] effDiag,
    output logic effAlt,
    output logic [3:0] effOvs,
    output logic effBip
);
    logic [13:0] topMask;
    logic [13:0] sensePat;

    ////////////////////////////////////////////////////////////////////////
    // position i is cell i+1; cells above the top cell are masked
    genvar i;
    generate
        for (i = 0; i < bsd_pkg::CH_N; i++) begin : g_top
            assign topMask[i] = (5'(i) < {1'b0, topCell});
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // overrides hold only while a scan runs, else the host setup passes
    always_comb begin
        effMeasA = measA;
        effMeasB = measB;
        effBal = balEn;
        effDiag = diagSel;
        effAlt = altSel;
        effOvs = ovs;
        effBip = 1'b0;
        sensePat = (sel == bsd_pkg::CFG_ODD) ? bsd_pkg::PAT_ODD :
            bsd_pkg::PAT_EVEN;
        if (running && bsd_pkg::isDiag(sel)) begin
            effMeasA[15:14] = 2'h0;
            effMeasB = 6'h00;
            effDiag = 4'h0;
            effAlt = 1'b1;
            case (sel)
                bsd_pkg::CFG_SHORT: begin
                    effBal = 14'h0000;
                    effMeasA[13:0] = measA[13:0] & ~polarity;
                end
                bsd_pkg::CFG_OPEN: begin
                    effMeasA[13:0] = balEn & ~polarity;
                    effBip = 1'b1;
                    effOvs = 4'h0;
                end
                default: begin
                    effBal = sensePat & ~polarity & topMask;
                    effMeasA[13:0] = sensePat & ~polarity & topMask;
                    effBip = 1'b1;
                    effOvs = 4'h0;
                end
            endcase
        end
    end

endmodule : bsd_override

//--- verilog/bsd_thresh_cmp.sv
// per-result threshold comparison of the switch diagnostic modes
`timescale 1ns/10ps
module bsd_thresh_cmp (
    input wire logic [2:0] sel,
    input wire logic [13:0] data,
    input wire logic [13:0] shortThr,
    input wire logic [13:0] lowThr,
    input wire logic [13:0] highThr,
    output logic fault
);
    ////////////////////////////////////////////////////////////////////////
    // codes compare unsigned; a result equal to a threshold is no fault
    always_comb begin
        if (sel == bsd_pkg::CFG_SHORT) begin
            fault = (data < shortThr);
        end else if (bsd_pkg::isDiag(sel)) begin
            fault = (data < lowThr) || (data > highThr);
        end else begin
            fault = 1'b0;
        end
    end

endmodule : bsd_thresh_cmp

//--- verilog/bsd_sequencer.sv
// switch diagnostic scan sequencer with its register file
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////
// Functional notes
// - short mode turns every balancing switch off during the scan
// - short mode measures only enabled unipolar cells
// - short mode compares unipolar results and flags the channel
// - short fault is a result below the short threshold only
// - all four diagnostic modes: alternate path on, block, aux and diag cleared
// - open mode converts bipolar
// - open mode measures enabled switches at unipolar positions
// - open mode flags results above high or below low threshold
// - open and sense modes force one sample per channel
// - sense modes close odd 1555h or even 2AAAh switches
// - sense pattern masks bipolar positions and those above top cell
// - sense modes measure active unipolar positions, bipolar
// - sense modes flag results outside low and high thresholds
// - alert cleared at diagnostic start, written at end, then kept
// - summary is the OR of all alert bits at scan end
// - overrides apply only while the scan runs, then restored
module bsd_sequencer #(
    parameter int CH_NUM = 14
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic acqDone,
    input wire logic resultValid,
    input wire logic [3:0] resultChannel,
    input wire logic [13:0] resultData,
    output logic acqStart,
    output logic scanBusy,
    output logic scanCompleteFlag,
    output logic [13:0] switchFaultAlert,
    output logic switchAlertSummary,
    output logic [15:0] effMeasureEnA,
    output logic [5:0] effMeasureEnB,
    output logic [13:0] effBalanceEn,
    output logic [3:0] effDiagSel,
    output logic effAltPath,
    output logic [3:0] effOversample,
    output logic effBipolar
);
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [2:0] cfgSel;
        logic altSel;
        logic [3:0] ovs;
        logic [15:0] measA;
        logic [5:0] measB;
        logic [13:0] balEn;
        logic [13:0] polarity;
        logic [3:0] diagSel;
        logic [3:0] topCell;
        logic [13:0] shortThr;
        logic [13:0] lowThr;
        logic [13:0] highThr;
        logic [13:0] alert;
        logic summary;
        logic done;
        logic [13:0] pending;
        bsd_pkg::bsd_phase_t phase;
        logic [2:0] runSel;
        logic acqStart;
        logic [15:0] effMeasA;
        logic [5:0] effMeasB;
        logic [13:0] effBal;
        logic [3:0] effDiag;
        logic effAlt;
        logic [3:0] effOvs;
        logic effBip;
    } bsd_state_t;

    bsd_state_t s;
    bsd_state_t next_s;
    logic [31:0] wd;
    logic [31:0] rd;
    logic [13:0] pend;
    logic req;
    logic running;
    logic fault;
    logic chanHit;
    logic [2:0] ovSel;
    logic [15:0] ovMeasA;
    logic [5:0] ovMeasB;
    logic [13:0] ovBal;
    logic [3:0] ovDiag;
    logic ovAlt;
    logic [3:0] ovOvs;
    logic ovBip;

    ////////////////////////////////////////////////////////////////////////
    // the channel count is fixed by the field widths of the map
    generate
        if (CH_NUM != bsd_pkg::CH_N) begin : g_chk
            $error("bsd_sequencer serves exactly 14 channels");
        end
    endgenerate

    // merge a write into an old word under the byte enables
    function automatic logic [31:0] beMerge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction : beMerge

    ////////////////////////////////////////////////////////////////////////
    // sub blocks: overrides from the held setup, comparison of results
    assign running = (s.phase != bsd_pkg::BSD_IDLE);
    assign ovSel = running ? s.runSel : s.cfgSel;

    bsd_override u_override (
        .running(running),
        .sel(ovSel),
        .measA(s.measA),
        .measB(s.measB),
        .balEn(s.balEn),
        .polarity(s.polarity),
        .diagSel(s.diagSel),
        .altSel(s.altSel),
        .ovs(s.ovs),
        .topCell(s.topCell),
        .effMeasA(ovMeasA),
        .effMeasB(ovMeasB),
        .effBal(ovBal),
        .effDiag(ovDiag),
        .effAlt(ovAlt),
        .effOvs(ovOvs),
        .effBip(ovBip)
    );

    bsd_thresh_cmp u_cmp (
        .sel(s.runSel),
        .data(resultData),
        .shortThr(s.shortThr),
        .lowThr(s.lowThr),
        .highThr(s.highThr),
        .fault(fault)
    );

    // only results of channels that the scan really measures count
    assign chanHit = resultValid && (resultChannel < 4'he) &&
        s.effMeasA[resultChannel];

    ////////////////////////////////////////////////////////////////////////
    // bus handshake: one wait cycle, frozen while the clock enable is low
    assign req = avs_read || avs_write;
    assign avs_waitrequest = req && !(s.ack && ce);
    assign avs_readdata = s.rdata;
    assign acqStart = s.acqStart;
    assign scanBusy = running;
    assign scanCompleteFlag = s.done;
    assign switchFaultAlert = s.alert;
    assign switchAlertSummary = s.summary;
    assign effMeasureEnA = s.effMeasA;
    assign effMeasureEnB = s.effMeasB;
    assign effBalanceEn = s.effBal;
    assign effDiagSel = s.effDiag;
    assign effAltPath = s.effAlt;
    assign effOversample = s.effOvs;
    assign effBipolar = s.effBip;

    ////////////////////////////////////////////////////////////////////////
    // next state: bus access first, so scan events set over any clear
    always_comb begin
        next_s = s;
        next_s.acqStart = 1'b0;
        wd = 32'h0000_0000;
        rd = 32'h0000_0000;
        pend = s.pending;
        // read view of the addressed word
        if (avs_address == bsd_pkg::OFS_CTRL) begin
            rd[bsd_pkg::CTRL_SEL_LSB +: 3] = s.cfgSel;
            rd[bsd_pkg::CTRL_ALT_BIT] = s.altSel;
            rd[bsd_pkg::CTRL_OVS_LSB +: 4] = s.ovs;
            rd[bsd_pkg::CTRL_BUSY_BIT] = running;
        end else if (avs_address == bsd_pkg::OFS_MEAS_A) begin
            rd = 32'(s.measA);
        end else if (avs_address == bsd_pkg::OFS_MEAS_B) begin
            rd = 32'(s.measB);
        end else if (avs_address == bsd_pkg::OFS_BAL_EN) begin
            rd = 32'(s.balEn);
        end else if (avs_address == bsd_pkg::OFS_POLARITY) begin
            rd = 32'(s.polarity);
        end else if (avs_address == bsd_pkg::OFS_DIAG_SEL) begin
            rd = 32'(s.diagSel);
        end else if (avs_address == bsd_pkg::OFS_TOP_CELL) begin
            rd = 32'(s.topCell);
        end else if (avs_address == bsd_pkg::OFS_SHORT_THR) begin
            rd = 32'(s.shortThr);
        end else if (avs_address == bsd_pkg::OFS_LOW_THR) begin
            rd = 32'(s.lowThr);
        end else if (avs_address == bsd_pkg::OFS_HIGH_THR) begin
            rd = 32'(s.highThr);
        end else if (avs_address == bsd_pkg::OFS_ALERT) begin
            rd = 32'(s.alert);
            rd[bsd_pkg::ALERT_SUM_BIT] = s.summary;
        end else if (avs_address == bsd_pkg::OFS_STATUS) begin
            rd[bsd_pkg::STAT_DONE_BIT] = s.done;
            rd[bsd_pkg::STAT_BUSY_BIT] = running;
        end
        next_s.ack = req && !s.ack;
        if (req && !s.ack) begin
            next_s.rdata = avs_read ? rd : 32'h0000_0000;
        end
        // writes take effect on the edge that completes the request
        if (s.ack && avs_write) begin
            wd = beMerge(rd, avs_writedata, avs_byteenable);
            if (avs_address == bsd_pkg::OFS_CTRL) begin
                next_s.cfgSel = wd[bsd_pkg::CTRL_SEL_LSB +: 3];
                next_s.altSel = wd[bsd_pkg::CTRL_ALT_BIT];
                next_s.ovs = wd[bsd_pkg::CTRL_OVS_LSB +: 4];
                // a start while busy is dropped, never queued
                if (wd[bsd_pkg::CTRL_START_BIT] && !running) begin
                    next_s.phase = bsd_pkg::BSD_ARM;
                    next_s.runSel = wd[bsd_pkg::CTRL_SEL_LSB +: 3];
                    next_s.pending = 14'h0000;
                    if (bsd_pkg::isDiag(wd[bsd_pkg::CTRL_SEL_LSB +: 3])) begin
                        next_s.alert = 14'h0000;
                    end
                end
            end else if (avs_address == bsd_pkg::OFS_MEAS_A) begin
                next_s.measA = wd[15:0];
            end else if (avs_address == bsd_pkg::OFS_MEAS_B) begin
                next_s.measB = wd[5:0];
            end else if (avs_address == bsd_pkg::OFS_BAL_EN) begin
                next_s.balEn = wd[13:0];
            end else if (avs_address == bsd_pkg::OFS_POLARITY) begin
                next_s.polarity = wd[13:0];
            end else if (avs_address == bsd_pkg::OFS_DIAG_SEL) begin
                next_s.diagSel = wd[3:0];
            end else if (avs_address == bsd_pkg::OFS_TOP_CELL) begin
                next_s.topCell = wd[3:0];
            end else if (avs_address == bsd_pkg::OFS_SHORT_THR) begin
                next_s.shortThr = wd[13:0];
            end else if (avs_address == bsd_pkg::OFS_LOW_THR) begin
                next_s.lowThr = wd[13:0];
            end else if (avs_address == bsd_pkg::OFS_HIGH_THR) begin
                next_s.highThr = wd[13:0];
            end else if (avs_address == bsd_pkg::OFS_ALERT) begin
                if (avs_byteenable[2] && !wd[bsd_pkg::ALERT_SUM_BIT]) begin
                    next_s.summary = 1'b0;
                end
            end else if (avs_address == bsd_pkg::OFS_STATUS) begin
                if (avs_byteenable[0] && avs_writedata[bsd_pkg::STAT_DONE_BIT])
                begin
                    next_s.done = 1'b0;
                end
            end
        end
        // scan sequencing
        case (s.phase)
            bsd_pkg::BSD_ARM: begin
                next_s.phase = bsd_pkg::BSD_RUN;
                next_s.acqStart = 1'b1; // overrides reach the outputs on this same edge
            end
            bsd_pkg::BSD_RUN: begin
                if (chanHit && fault) begin
                    pend[resultChannel] = 1'b1;
                end
                next_s.pending = pend;
                if (acqDone) begin
                    next_s.phase = bsd_pkg::BSD_IDLE;
                    next_s.done = 1'b1;
                    if (bsd_pkg::isDiag(s.runSel)) begin
                        next_s.alert = pend;
                        next_s.summary = |pend;
                    end
                end
            end
            default: begin
            end
        endcase
        // effective setup follows one cycle behind the held setup
        next_s.effMeasA = ovMeasA;
        next_s.effMeasB = ovMeasB;
        next_s.effBal = ovBal;
        next_s.effDiag = ovDiag;
        next_s.effAlt = ovAlt;
        next_s.effOvs = ovOvs;
        next_s.effBip = ovBip;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register; the clock enable freezes everything
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.measA <= bsd_pkg::RST_MEAS_A;
            s.effMeasA <= bsd_pkg::RST_MEAS_A;
            s.topCell <= bsd_pkg::RST_TOP_CELL;
            s.highThr <= bsd_pkg::RST_HIGH_THR;
        end else if (ce) begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks on the driven behaviour
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence startDiag_s;
        ce && s.ack && avs_write && (avs_address == bsd_pkg::OFS_CTRL) &&
        avs_byteenable[1] && avs_byteenable[0] && !running &&
        avs_writedata[bsd_pkg::CTRL_START_BIT] && avs_writedata[2];
    endsequence

    sequence scanEnd_s;
        ce && (s.phase == bsd_pkg::BSD_RUN) && acqDone &&
        bsd_pkg::isDiag(s.runSel);
    endsequence

    switch_off_a: assert property (
        (s.phase == bsd_pkg::BSD_RUN) && (s.runSel == bsd_pkg::CFG_SHORT)
        |-> (s.effBal == 14'h0000))
        else $error("switches not off in short scan");

    short_meas_a: assert property (
        (s.phase == bsd_pkg::BSD_RUN) && (s.runSel == bsd_pkg::CFG_SHORT) &&
        $past(ce) |-> (s.effMeasA[13:0] ==
        ($past(s.measA[13:0]) & ~$past(s.polarity))))
        else $error("short scan measures wrong cells");

    common_ovr_a: assert property (
        (s.phase == bsd_pkg::BSD_RUN) && bsd_pkg::isDiag(s.runSel) |->
        s.effAlt && (s.effMeasA[15:14] == 2'h0) && (s.effMeasB == 6'h00)
        && (s.effDiag == 4'h0))
        else $error("common overrides missing");

    bipolar_ovs_a: assert property (
        (s.phase == bsd_pkg::BSD_RUN) && bsd_pkg::isBipolarMode(s.runSel)
        |-> s.effBip && (s.effOvs == 4'h0))
        else $error("bipolar or single sample not forced");

    open_meas_a: assert property (
        (s.phase == bsd_pkg::BSD_RUN) && (s.runSel == bsd_pkg::CFG_OPEN) &&
        $past(ce) |-> (s.effMeasA[13:0] ==
        ($past(s.balEn) & ~$past(s.polarity))))
        else $error("open scan measures wrong positions");

    sense_pat_a: assert property (
        (s.phase == bsd_pkg::BSD_RUN) && (s.runSel == bsd_pkg::CFG_ODD) |->
        ((s.effBal & ~bsd_pkg::PAT_ODD) == 14'h0000) &&
        (s.effMeasA[13:0] == s.effBal))
        else $error("odd pattern wrong");

    sense_mask_a: assert property (
        (s.phase == bsd_pkg::BSD_RUN) && (s.runSel == bsd_pkg::CFG_EVEN) &&
        $past(ce) |-> ((s.effBal & $past(s.polarity)) == 14'h0000) &&
        ((s.effBal & ~bsd_pkg::PAT_EVEN) == 14'h0000))
        else $error("even pattern not masked");

    short_flag_a: assert property (
        ce && (s.phase == bsd_pkg::BSD_RUN) && chanHit && !acqDone &&
        (s.runSel == bsd_pkg::CFG_SHORT) |=>
        (s.pending[$past(resultChannel)] ==
        ($past(s.pending[resultChannel]) ||
        ($past(resultData) < $past(s.shortThr)))))
        else $error("short compare wrong");

    window_flag_a: assert property (
        ce && (s.phase == bsd_pkg::BSD_RUN) && chanHit && !acqDone &&
        bsd_pkg::isBipolarMode(s.runSel) && (resultData > s.highThr) |=>
        s.pending[$past(resultChannel)])
        else $error("high threshold fault not flagged");

    clear_start_a: assert property (
        startDiag_s |=> (((s.alert == 14'h0000) &&
        (s.phase == bsd_pkg::BSD_ARM)) and (ce |=> s.acqStart)))
        else $error("alert not cleared or scan not started");

    end_sum_a: assert property (
        scanEnd_s |=> (switchAlertSummary == (|switchFaultAlert)) &&
        s.done && !running)
        else $error("summary not updated at scan end");

    restore_a: assert property (
        !running && $past(!running) && $past(ce) |->
        (s.effBal == $past(s.balEn)) && !s.effBip &&
        (s.effMeasA == $past(s.measA)))
        else $error("setup not restored after scan");

endmodule : bsd_sequencer

//--- sim/bsd_acq_model.sv
// behavioural acquisition engine answering the sequencer's start pulse
`timescale 1ns/10ps
module bsd_acq_model (
    input wire logic ref_clk,
    input wire logic acqStart,
    input wire logic [13:0] base,
    input wire logic [13:0] step,
    output logic resultValid = 0,
    output logic [3:0] resultChannel = 0,
    output logic [13:0] resultData = 0,
    output logic acqDone = 0
);
    // one result per channel, channel 14 too so the refusal path is hit;
    // data flips between results so a stale value never looks valid
    always begin
        @(posedge ref_clk);
        if (acqStart === 1'b1) begin
            repeat (3) @(posedge ref_clk);
            for (int c = 0; c < 15; c++) begin
                resultValid <= 1'b1;
                resultChannel <= 4'(c);
                resultData <= base + 14'(c) * step;
                @(posedge ref_clk);
                resultValid <= 1'b0;
                resultData <= ~resultData;
                @(posedge ref_clk);
            end
            acqDone <= 1'b1;
            @(posedge ref_clk);
            acqDone <= 1'b0;
        end
    end
endmodule : bsd_acq_model

//--- sim/balance_switch_diag_sequencer_tb.sv
// self-checking bench of the switch diagnostic sequencer
`timescale 1ns/10ps
module balance_switch_diag_sequencer_tb;
logic ref_clk = 0, rst_n = 0, rdReq = 0, wrReq = 0, wreq, start, busy, alt;
logic bip, valid, aDone, done, sum;
logic [5:0] adr = 0, mB;
logic [31:0] wdat = 0, rdat, q;
logic [3:0] ch, dsel, ovs;
logic [13:0] base = 14'h0040, step = 14'h0040, data, alert, bal;
logic [15:0] mA;
int fails = 0, comparisons = 0;
always #50 ref_clk = ~ref_clk;
bsd_sequencer i_bsd_sequencer (.ref_clk(ref_clk), .rst_n(rst_n),
    .ce(1'b1), .avs_address(adr), .avs_read(rdReq), .avs_write(wrReq),
    .avs_writedata(wdat), .avs_byteenable(4'hf), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .acqDone(aDone), .resultValid(valid),
    .resultChannel(ch), .resultData(data), .acqStart(start),
    .scanBusy(busy), .scanCompleteFlag(done), .switchFaultAlert(alert),
    .switchAlertSummary(sum), .effMeasureEnA(mA), .effMeasureEnB(mB),
    .effBalanceEn(bal), .effDiagSel(dsel), .effAltPath(alt),
    .effOversample(ovs), .effBipolar(bip));
bsd_acq_model i_bsd_acq_model (.ref_clk(ref_clk), .acqStart(start),
    .base(base), .step(step), .resultValid(valid), .resultChannel(ch),
    .resultData(data), .acqDone(aDone));
// verdict and end of run
task complete_run;
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
endtask : complete_run
task chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
        fails++;
        $display("unexpected at %0t: saw %h, wanted %h", $time, s, e);
    end
endtask : chk
// one avalon transfer, held until waitrequest is seen low at an edge
task acc(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    adr <= a;
    wdat <= d;
    wrReq <= w;
    rdReq <= !w;
    do @(posedge ref_clk); while (wreq !== 1'b0);
    q = rdat;
    wrReq <= 1'b0;
    rdReq <= 1'b0;
endtask : acc
// one diagnostic scan; msk is the expected measured set
task scan(input logic [2:0] m, input logic [13:0] msk);
    logic [13:0] e, d;
    logic sh;
    sh = (m == bsd_pkg::CFG_SHORT);
    for (int c = 0; c < 14; c++) begin
        d = base + 14'(c) * step;
        e[c] = msk[c] & (sh ? d < 14'h0100 : (d < 14'h0080 | d > 14'h0200));
    end
    acc(1, bsd_pkg::OFS_CTRL, {23'h0, 1'b0, 4'h3, 1'b0, m});
    if (m[1]) repeat (1000) @(posedge ref_clk);
    acc(1, bsd_pkg::OFS_CTRL, {23'h0, 1'b1, 4'h3, 1'b0, m});
    do @(negedge ref_clk); while (start !== 1'b1);
    chk(bal, sh ? 14'h0 : msk);
    chk(mA, {2'b00, msk});
    chk({mB, dsel, alt}, {6'h0, 4'h0, 1'b1});
    chk({ovs, bip}, sh ? 5'h06 : 5'h01);
    chk(alert, 0);
    do @(negedge ref_clk); while (busy !== 1'b0);
    repeat (2) @(negedge ref_clk);
    chk({done, sum, alert}, {1'b1, |e, e});
    chk({mA, alt}, {16'hffff, 1'b0});
    chk({bal, ovs, bip}, {14'h00f3, 4'h3, 1'b0});
    chk({mB, dsel}, {6'h3f, 4'h5});
    acc(0, bsd_pkg::OFS_ALERT, 0);
    chk(q, {15'h0, |e, 2'b00, e});
    acc(0, bsd_pkg::OFS_STATUS, 0);
    chk(q[0], 1'b1);
endtask : scan
// main sequence: reset values, setup, all four modes
initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    acc(0, bsd_pkg::OFS_MEAS_A, 0);
    chk(q, 32'h3fff);
    acc(0, bsd_pkg::OFS_TOP_CELL, 0);
    chk(q, 32'he);
    acc(0, bsd_pkg::OFS_HIGH_THR, 0);
    chk(q, 32'h3fff);
    acc(1, 6'h3c, 32'hffff);
    acc(0, 6'h3c, 0);
    chk(q, 32'h0);
    acc(1, bsd_pkg::OFS_POLARITY, 32'h4);
    acc(1, bsd_pkg::OFS_MEAS_A, 32'hffff);
    acc(1, bsd_pkg::OFS_MEAS_B, 32'h3f);
    acc(1, bsd_pkg::OFS_DIAG_SEL, 32'h5);
    acc(1, bsd_pkg::OFS_BAL_EN, 32'h00f3);
    acc(1, bsd_pkg::OFS_SHORT_THR, 32'h0100);
    acc(1, bsd_pkg::OFS_LOW_THR, 32'h0080);
    acc(1, bsd_pkg::OFS_HIGH_THR, 32'h0200);
    acc(1, bsd_pkg::OFS_TOP_CELL, 32'hc);
    scan(bsd_pkg::CFG_OPEN, 14'h00f3);
    scan(bsd_pkg::CFG_SHORT, 14'h3ffb);
    scan(bsd_pkg::CFG_ODD, 14'h0551);
    scan(bsd_pkg::CFG_EVEN, 14'h0aaa);
    // done is write-one-to-clear, the summary clears on a written zero
    acc(1, bsd_pkg::OFS_STATUS, 32'h1);
    acc(0, bsd_pkg::OFS_STATUS, 0);
    chk(q, 32'h0);
    acc(1, bsd_pkg::OFS_ALERT, 0);
    acc(0, bsd_pkg::OFS_ALERT, 0);
    chk(q, 32'h0a00);
    // a normal scan neither overrides the setup nor touches the alert
    acc(1, bsd_pkg::OFS_CTRL, 32'h103);
    do @(negedge ref_clk); while (start !== 1'b1);
    chk({mA, bal, bip}, {16'hffff, 14'h00f3, 1'b0});
    do @(negedge ref_clk); while (busy !== 1'b0);
    chk({done, sum, alert}, {1'b1, 1'b0, 14'h0a00});
    complete_run;
end
// watchdog against a hung handshake or scan
initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    complete_run;
end
endmodule : balance_switch_diag_sequencer_tb
